// ===== design/hlc_regs.v
// closed-loop configuration and calibration result register bank
//
// Function
// - closed-loop automatic overdrive is limited to the overdrive limit register.
// - open loop uses the overdrive limit register as full-scale reference.
// - calibration stores measured voltage compensation into the compensation register.
// - playback gain is multiplied by one plus compensation over 255.
// - calibration stores back-emf at rated level; it sets the bemf_mv level output.
// - back-emf level equals value over 255 times 1.22 V over gain.
// - feedback control: type bit 7, brake 6:4, loop 3:2, bemf 1:0.
// - type bit 0 selects rotating mass, 1 selects linear resonant.
// - brake ratio codes 1x,2x,3x,4x,6x,8x,16x; code 7 disables braking.
`timescale 1ns/1ps
`include "hlc_defs.vh"
module hlc_regs (
   // clock and reset
   input wire sys_clk,
   input wire nrst,
   // register port
   input wire reg_wr,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   // calibration engine
   input wire cal_done,
   input wire [7:0] cal_comp,
   input wire [7:0] cal_bemf,
   // playback engine
   input wire closed_loop,
   input wire [7:0] rated_level,
   input wire [7:0] drive_req,
   output reg [7:0] drive_level,
   output reg [8:0] comp_coef,
   output reg [4:0] brake_mult,
   output reg brake_enable,
   output reg [15:0] bemf_mv,
   output reg actuator_type_select,
   output reg [1:0] loop_gain,
   output reg [1:0] backemf_scale_gain
);
   reg [7:0] overdrive_limit;
   reg [7:0] calib_comp_result;
   reg [7:0] calib_backemf_result;
   reg [7:0] loop_feedback_control;
   wire [8:0] s_comp;
   wire [4:0] s_brake;
   wire s_brake_en;
   wire [15:0] s_bemf;
   reg [7:0] next_rdata;
   reg [7:0] next_drive;
   reg [7:0] ref_level;

   hlc_scale u_scale (
      .comp_value(calib_comp_result),
      .bemf_value(calib_backemf_result),
      .brake_code(loop_feedback_control[`HLC_FB_BRAKE_MSB:`HLC_FB_BRAKE_LSB]),
      .backemf_scale_gain_code(loop_feedback_control[`HLC_FB_BEMF_MSB:`HLC_FB_BEMF_LSB]),
      .comp_coef(s_comp),
      .brake_mult(s_brake),
      .brake_enable(s_brake_en),
      .bemf_mv(s_bemf)
   );

   // host writes and calibration results; calibration wins on collision
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         overdrive_limit <= `HLC_RST_OVERDRIVE;
         calib_comp_result <= `HLC_RST_COMP;
         calib_backemf_result <= `HLC_RST_BEMF;
         loop_feedback_control <= `HLC_RST_FBCTL;
      end else begin
         if (reg_wr && reg_addr == `HLC_ADDR_OVERDRIVE) begin
            overdrive_limit <= reg_wdata;
         end
         if (reg_wr && reg_addr == `HLC_ADDR_FBCTL) begin
            loop_feedback_control <= reg_wdata;
         end
         if (cal_done) begin
            calib_comp_result <= cal_comp;
            calib_backemf_result <= cal_bemf;
         end else begin
            if (reg_wr && reg_addr == `HLC_ADDR_COMP) begin
               calib_comp_result <= reg_wdata;
            end
            if (reg_wr && reg_addr == `HLC_ADDR_BEMF) begin
               calib_backemf_result <= reg_wdata;
            end
         end
      end
   end

   always @* begin
      case (reg_addr)
         `HLC_ADDR_OVERDRIVE: next_rdata = overdrive_limit;
         `HLC_ADDR_COMP: next_rdata = calib_comp_result;
         `HLC_ADDR_BEMF: next_rdata = calib_backemf_result;
         `HLC_ADDR_FBCTL: next_rdata = loop_feedback_control;
         default: next_rdata = 8'h00;
      endcase
      // open loop: full scale is the limit; closed loop: rated level
      ref_level = closed_loop ? rated_level : overdrive_limit;
      next_drive = drive_req;
      if (closed_loop && drive_req > overdrive_limit) begin
         next_drive = overdrive_limit;
      end
      if (!closed_loop && drive_req > ref_level) begin
         next_drive = ref_level;
      end
   end

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
         drive_level <= 8'h00;
         comp_coef <= 9'h000;
         brake_mult <= 5'h00;
         brake_enable <= 1'b0;
         bemf_mv <= 16'h0000;
         actuator_type_select <= 1'b0;
         loop_gain <= 2'h0;
         backemf_scale_gain <= 2'h0;
      end else begin
         reg_rdata <= next_rdata;
         drive_level <= next_drive;
         comp_coef <= s_comp;
         brake_mult <= s_brake;
         brake_enable <= s_brake_en;
         bemf_mv <= s_bemf;
         actuator_type_select <=
            loop_feedback_control[`HLC_FB_TYPE_BIT];
         loop_gain <=
            loop_feedback_control[`HLC_FB_LOOP_MSB:`HLC_FB_LOOP_LSB];
         backemf_scale_gain <=
            loop_feedback_control[`HLC_FB_BEMF_MSB:`HLC_FB_BEMF_LSB];
      end
   end
endmodule // hlc_regs

// ===== design/hlc_defs.vh
// register map, field positions, reset values and coefficient scaling
`ifndef HLC_DEFS_VH
`define HLC_DEFS_VH
`define HLC_ADDR_OVERDRIVE 8'h17
`define HLC_ADDR_COMP 8'h18
`define HLC_ADDR_BEMF 8'h19
`define HLC_ADDR_FBCTL 8'h1A
`define HLC_RST_OVERDRIVE 8'h89
`define HLC_RST_COMP 8'h0D
`define HLC_RST_BEMF 8'h6D
`define HLC_RST_FBCTL 8'h36
`define HLC_FB_TYPE_BIT 7
`define HLC_FB_BRAKE_MSB 6
`define HLC_FB_BRAKE_LSB 4
`define HLC_FB_LOOP_MSB 3
`define HLC_FB_LOOP_LSB 2
`define HLC_FB_BEMF_MSB 1
`define HLC_FB_BEMF_LSB 0
`define HLC_FULL_SCALE 8'hFF
`define HLC_BEMF_FS_MV 16'h04C4
`define HLC_BRAKE_OFF 3'h7
`endif

// ===== design/hlc_scale.v
// coefficient decode: compensation, brake ratio, back-emf level
`timescale 1ns/1ps
`include "hlc_defs.vh"
module hlc_scale (
   // settings
   input wire [7:0] comp_value,
   input wire [7:0] bemf_value,
   input wire [2:0] brake_code,
   input wire [1:0] backemf_scale_gain_code,
   // derived
   output reg [8:0] comp_coef,
   output reg [4:0] brake_mult,
   output reg brake_enable,
   output reg [15:0] bemf_mv
);
   reg [23:0] prod;
   reg [23:0] quot;
   reg [2:0] gain;
   always @* begin
      // coefficient as 1 + value/255, fixed point with 255 as one
      comp_coef = {1'b0, `HLC_FULL_SCALE} + {1'b0, comp_value};
      brake_enable = (brake_code != `HLC_BRAKE_OFF);
      case (brake_code)
         3'h0: brake_mult = 5'h01;
         3'h1: brake_mult = 5'h02;
         3'h2: brake_mult = 5'h03;
         3'h3: brake_mult = 5'h04;
         3'h4: brake_mult = 5'h06;
         3'h5: brake_mult = 5'h08;
         3'h6: brake_mult = 5'h10;
         default: brake_mult = 5'h00;
      endcase
      // gain setting taken as code plus one, avoiding a divide by zero
      gain = {1'b0, backemf_scale_gain_code} + 3'h1;
      prod = {16'h0000, bemf_value} * `HLC_BEMF_FS_MV;
      // divide by full scale first; floor of floor equals one floor
      quot = prod / {16'h0000, `HLC_FULL_SCALE};
      bemf_mv = quot[15:0] / {13'h0000, gain};
   end
endmodule // hlc_scale

// ===== tb/hlc_cal_model.sv
// calibration engine stand-in with fixed results
`timescale 1ns/1ps
module hlc_cal_model (
   // control
   input wire sys_clk,
   input wire start,
   // results
   output reg cal_done,
   output reg [7:0] cal_comp,
   output reg [7:0] cal_bemf
);
   initial {cal_done, cal_comp, cal_bemf} = 17'h0;
   always @(posedge start) begin
      repeat (3) @(negedge sys_clk);
      {cal_done, cal_comp, cal_bemf} <= {1'b1, 16'h2A91};
      @(negedge sys_clk);
      {cal_done, cal_comp, cal_bemf} <= {1'b0, 16'hD56E};
   end
endmodule // hlc_cal_model

// ===== tb/hlc_regs_chk.sv
// port assertions for the register bank
`timescale 1ns/1ps
module hlc_regs_chk (
   // register side
   input wire sys_clk, nrst, reg_wr, cal_done,
   input wire [7:0] reg_addr, reg_wdata, reg_rdata, cal_comp,
   // playback side
   input wire [7:0] drive_req, drive_level,
   input wire [8:0] comp_coef,
   input wire [4:0] brake_mult,
   input wire brake_enable, actuator_type_select,
   input wire [1:0] loop_gain, backemf_scale_gain
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   sequence q; !reg_wr && !cal_done; endsequence
   sequence w(a); reg_wr && reg_addr == a && !cal_done; endsequence
   comp_write_a: assert property ((w(8'h18) ##1 q [*3]) |->
      comp_coef == 9'h0FF + $past(reg_wdata, 3)) else $error("comp");
   cal_load_a: assert property ((cal_done ##1 q [*3]) |->
      comp_coef == 9'h0FF + $past(cal_comp, 3)) else $error("cal");
   fb_fields_a: assert property ((w(8'h1A) ##1 q [*3]) |->
      {actuator_type_select, loop_gain, backemf_scale_gain} ==
      {$past(reg_wdata[7], 3), $past(reg_wdata[3:0], 3)}) else $error("fb");
   brake_off_a: assert property ((w(8'h1A) ##1 q [*3]) |->
      brake_enable == ($past(reg_wdata[6:4], 3) != 3'h7)) else $error("brk");
   brake_mult_a: assert property (brake_enable == (brake_mult != 5'h00))
      else $error("mult");
   clamp_req_a: assert property (drive_level <= $past(drive_req))
      else $error("req");
   clamp_lim_a: assert property ((w(8'h17) ##1 q [*3]) |->
      drive_level <= $past(reg_wdata, 3)) else $error("lim");
   unmapped_read_a: assert property (reg_addr < 8'h17 || reg_addr > 8'h1A |=>
      reg_rdata == 8'h00) else $error("unmapped");
   cal_c: cover property (cal_done);
   off_c: cover property (w(8'h1A) ##1 q [*3] ##0 !brake_enable);
   lim_c: cover property (drive_level < drive_req);
endmodule // hlc_regs_chk
bind hlc_regs hlc_regs_chk chk_u (.sys_clk, .nrst, .reg_wr, .cal_done,
   .reg_addr, .reg_wdata, .reg_rdata, .cal_comp, .drive_req, .drive_level,
   .comp_coef, .brake_mult, .brake_enable, .actuator_type_select,
   .loop_gain, .backemf_scale_gain);

// ===== tb/haptic_loop_calib_regs_tb.sv
// bench for the calibration register bank
`timescale 1ns/1ps
module haptic_loop_calib_regs_tb;
   reg sys_clk = 0, nrst = 0, reg_wr = 0, closed_loop = 1, start = 0;
   reg [7:0] reg_addr = 0, reg_wdata = 0, drive_req = 0;
   wire [7:0] reg_rdata, drive_level, cal_comp, cal_bemf;
   wire [8:0] comp_coef;
   wire [15:0] bemf_mv;
   reg [7:0] rated_level = 0;
   wire [4:0] brake_mult;
   wire [1:0] loop_gain, backemf_scale_gain;
   wire cal_done, brake_enable, actuator_type_select;
   integer n_fail = 0, checks_done = 0, i, e;
   always #2 sys_clk = ~sys_clk;
   hlc_regs dut_u (.sys_clk, .nrst, .reg_wr, .reg_addr, .reg_wdata,
      .reg_rdata, .cal_done, .cal_comp, .cal_bemf, .closed_loop,
      .rated_level, .drive_req, .drive_level, .comp_coef, .brake_mult,
      .brake_enable, .bemf_mv, .actuator_type_select, .loop_gain,
      .backemf_scale_gain);
   hlc_cal_model cal_u (.sys_clk, .start, .cal_done, .cal_comp, .cal_bemf);
   task chk(input [15:0] got, input [15:0] exp, input string what);
      begin
         checks_done++;
         if (got !== exp) begin
            n_fail++;
            $display("mismatch %0s exp %h got %h", what, exp, got);
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      @(negedge sys_clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
      @(negedge sys_clk) reg_wr = 0;
   endtask
   task rd(input [7:0] a, input [7:0] e);
      @(negedge sys_clk) reg_addr = a;
      repeat (2) @(negedge sys_clk);
      chk(reg_rdata, e, "rdata");
   endtask
   task t_regs;
      begin
         rd(8'h17, 8'h89);
         rd(8'h18, 8'h0D);
         rd(8'h19, 8'h6D);
         rd(8'h1A, 8'h36);
         chk(bemf_mv, 16'h00AD, "bemf");
         for (i = 0; i < 4; i++) wr(8'h17 + i, 8'hF3 - i);
         for (i = 0; i < 4; i++) rd(8'h17 + i, 8'hF3 - i);
         chk({actuator_type_select, brake_enable}, 2'b10, "type");
         chk(comp_coef, 9'h1F1, "coef");
         chk(bemf_mv, 16'h0481, "bemf");
         wr(8'h20, 8'h55);
         rd(8'h20, 8'h00);
         $display("test regs done");
      end
   endtask
   task t_brake;
      for (i = 0; i < 8; i++) begin
         wr(8'h1A, {1'b0, i[2:0], 4'h9});
         repeat (3) @(negedge sys_clk);
         case (i)
            4: e = 6;
            5: e = 8;
            6: e = 16;
            7: e = 0;
            default: e = i + 1;
         endcase
         chk(brake_mult, e, "mult");
         chk(brake_enable, i != 7, "brken");
         chk({actuator_type_select, loop_gain, backemf_scale_gain}, 5'h09,
            "fields");
      end
      chk(bemf_mv, 16'h0240, "bemf");
      $display("test brake done");
   endtask
   task t_clamp;
      wr(8'h17, 8'h40);
      drive_req = 8'hFF;
      repeat (3) @(negedge sys_clk);
      chk(drive_level, 8'h40, "closed");
      closed_loop = 0;
      repeat (2) @(negedge sys_clk);
      chk(drive_level, 8'h40, "open");
      drive_req = 8'h10;
      repeat (2) @(negedge sys_clk);
      chk(drive_level, 8'h10, "low");
      $display("test clamp done");
   endtask
   task t_cal;
      wr(8'h18, 8'h5A);
      repeat (3) @(negedge sys_clk);
      chk(comp_coef, 9'h159, "wrcoef");
      rated_level = 8'h3F;
      @(negedge sys_clk) start = 1;
      @(negedge sys_clk) start = 0;
      repeat (6) @(negedge sys_clk);
      chk(comp_coef, 9'h129, "calcoef");
      rd(8'h19, 8'h91);
      chk(bemf_mv, 16'h015A, "calbemf");
      $display("test cal done");
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (6) @(negedge sys_clk);
      nrst = 1;
      t_regs;
      t_brake;
      t_clamp;
      t_cal;
      close_out;
   end
   initial begin
      #3000;
      n_fail++;
      close_out;
   end
endmodule // haptic_loop_calib_regs_tb
